// ### crl_regs.svh
// Register addresses, field positions, reset values and command codes of the readout logic
`ifndef CRL_REGS_SVH
`define CRL_REGS_SVH

// ==========================================
// Addresses
`define CRL_ADDR_CTRL      2'h3

// ==========================================
// Control word fields
`define CRL_SC_HI          7
`define CRL_SC_LO          6
`define CRL_RW_HI          5
`define CRL_RW_LO          4
`define CRL_SC_READBACK    2'h3
`define CRL_RW_LATCH       2'h0
`define CRL_RW_LSB         2'h1
`define CRL_RW_MSB         2'h2
`define CRL_RW_BOTH        2'h3
`define CRL_MODE_SQUARE    3'h3
`define CRL_MODE_ONESHOT   3'h0

// ==========================================
// Read-back command fields
`define CRL_RB_COUNT_N     5
`define CRL_RB_STATUS_N    4
`define CRL_RB_SEL_LO      1

// ==========================================
// Status byte fields
`define CRL_ST_OUT         7
`define CRL_ST_NULL        6

// ==========================================
// Reset values
`define CRL_CTRL_RESET     6'h30
`define CRL_COUNT_RESET    16'h0000

`endif

// ### crl_pkg.sv
// Types shared by the counter readout latch logic
package crl_pkg;
	typedef logic [15:0] crl_count_t;
	typedef logic [5:0]  crl_ctrl_t;
	typedef logic [7:0]  crl_byte_t;
endpackage

// ### crl_channel.sv
// Counting element of one counter: down-counting, load from the count load register
`include "crl_regs.svh"
module crl_channel
(
	input  wire logic              clk,
	input  wire logic              reset,
	input  wire logic              tick,
	input  wire logic              gate_on,
	input  wire logic              ctrl_wr,
	input  wire logic [2:0]        op_sel,
	input  wire logic              load_req,
	input  wire crl_pkg::crl_count_t count_load_register,
	output crl_pkg::crl_count_t    count_value,
	output logic                   out_level,
	output logic                   loaded
);
	crl_pkg::crl_count_t count_r, count_nxt, load_val;
	logic                out_r, out_nxt;
	logic                loaded_nxt, square;

	// ==========================================
	// Counting element
	always_comb
	begin
		square     = (op_sel[1:0] == 2'(`CRL_MODE_SQUARE)) ? 1'b1 : 1'b0;
		load_val   = square ? {count_load_register[15:1], 1'b0} : count_load_register;
		count_nxt  = count_r;
		out_nxt    = out_r;
		loaded_nxt = 1'b0;
		if (ctrl_wr)
			out_nxt = (op_sel == `CRL_MODE_ONESHOT) ? 1'b0 : 1'b1;
		else if (tick && load_req)
		begin
			count_nxt  = load_val;
			loaded_nxt = 1'b1;
		end
		else if (tick && gate_on)
		begin
			if (square)
			begin
				// Square wave steps by two and flips the output at each reload
				if (count_r <= 16'h0002)
				begin
					count_nxt = load_val; // [R15]
					out_nxt   = ~out_r;
				end
				else
					count_nxt = count_r - 16'h0002; // [R15]
			end
			else
			begin
				count_nxt = count_r - 16'h0001; // [R15]
				if (count_r == 16'h0001 && op_sel == `CRL_MODE_ONESHOT)
					out_nxt = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			count_r <= `CRL_COUNT_RESET;
			out_r   <= 1'b0;
			loaded  <= 1'b0;
		end
		else
		begin
			count_r <= count_nxt;
			out_r   <= out_nxt;
			loaded  <= loaded_nxt;
		end
	end

	assign count_value = count_r;
	assign out_level   = out_r;
endmodule

// ### crl_top.sv
// Three-counter timer readout: counter latch, read-back command, status byte, byte sequencing
// Notes on behaviour
// [R1] Direct reads of a running counter may be wrong; host stops gate or clock.
// [R2] Counter latch command copies current count into hold latch; counting continues.
// [R3] Latched count stays frozen until read or a new control word.
// [R4] A repeated latch command before the read is ignored.
// [R5] Read and write byte pointers of one counter are independent.
// [R6] Read-back command has top bits 11; D1, D2, D3 select counters 0, 1, 2.
// [R7] Read-back may latch several counters; reading one releases only that one.
// [R8] Repeated read-back latches of a counter before its read are ignored.
// [R9] Status byte: output level D7, null count D6, control fields D5 to D0.
// [R10] Null count per counter: set on control or count write, cleared on load.
// [R11] With two-byte counts null count sets only on the second byte.
// [R12] Repeated status latch before status read is ignored.
// [R13] Count and status latch bits active low; both zero latches both.
// [R14] With both latched, first read gives status, then the count bytes.
// [R15] Counters count down, in steps of two in square-wave mode.
// [R16] Host writes read-back bit D0 as zero; treated as reserved.
`include "crl_regs.svh"
module crl_top
(
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       cs_n,
	input  wire logic       rd_n,
	input  wire logic       wr_n,
	input  wire logic [1:0] addr,
	input  wire logic [7:0] data_in,
	output logic [7:0]      data_out,
	output logic            data_oe,
	input  wire logic [2:0] counter_clk,
	input  wire logic [2:0] gate,
	output logic [2:0]      counter_out
);
	// ==========================================
	// Pin synchronisers
	logic [13:0] bus_s1_r, bus_s2_r;
	logic [5:0]  cnt_s1_r, cnt_s2_r;
	logic        wr_prev_r, rd_prev_r;
	logic [2:0]  clk_prev_r;

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			// Idle bus: select and both strobes high, so no false strobe edge follows reset
			bus_s1_r   <= 14'h3800;
			bus_s2_r   <= 14'h3800;
			cnt_s1_r   <= 6'h00;
			cnt_s2_r   <= 6'h00;
			wr_prev_r  <= 1'b1;
			rd_prev_r  <= 1'b1;
			clk_prev_r <= 3'h0;
		end
		else
		begin
			bus_s1_r   <= {cs_n, rd_n, wr_n, addr, data_in, 1'b0};
			bus_s2_r   <= bus_s1_r;
			cnt_s1_r   <= {gate, counter_clk};
			cnt_s2_r   <= cnt_s1_r;
			wr_prev_r  <= bus_s2_r[11];
			rd_prev_r  <= bus_s2_r[12];
			clk_prev_r <= cnt_s2_r[2:0];
		end
	end

	logic                cs_s, rd_s, wr_s;
	logic [1:0]          addr_s;
	crl_pkg::crl_byte_t  din_s;
	logic                wr_end, rd_end;
	logic [2:0]          tick, gate_on;

	assign cs_s    = ~bus_s2_r[13];
	assign rd_s    = ~bus_s2_r[12];
	assign wr_s    = ~bus_s2_r[11];
	assign addr_s  = bus_s2_r[10:9];
	assign din_s   = bus_s2_r[8:1];
	// Writes and reads act at the trailing edge of the strobe
	assign wr_end  = cs_s & ~wr_prev_r & ~wr_s;
	assign rd_end  = cs_s & ~rd_prev_r & ~rd_s;
	assign tick    = clk_prev_r & ~cnt_s2_r[2:0];
	assign gate_on = cnt_s2_r[5:3];

	// ==========================================
	// Command decode
	logic       ctrl_wr, is_rb;
	logic [1:0] sc;

	assign ctrl_wr = wr_end && addr_s == `CRL_ADDR_CTRL;
	assign sc      = din_s[`CRL_SC_HI:`CRL_SC_LO];
	assign is_rb   = ctrl_wr && sc == `CRL_SC_READBACK; // [R6]

	crl_pkg::crl_byte_t rd_byte [3];

	// ==========================================
	// Per-counter latches, registers and pointers
	genvar g;
	generate
		for (g = 0; g < 3; g++)
		begin : g_ch
			crl_pkg::crl_ctrl_t  ctrl_r, ctrl_nxt;
			crl_pkg::crl_count_t cr_r, cr_nxt, ol_r, ol_nxt, ce;
			crl_pkg::crl_byte_t  st_r, st_nxt;
			logic ol_v_r, ol_v_nxt, st_v_r, st_v_nxt, null_r, null_nxt;
			logic rmsb_r, rmsb_nxt, wmsb_r, wmsb_nxt, ld_r, ld_nxt;
			logic sel_ctrl, sel_latch, rb_hit, wr_cnt, rd_cnt, loaded, out_lv;
			logic [1:0] fmt;

			assign sel_ctrl  = ctrl_wr && sc == 2'(g) && din_s[`CRL_RW_HI:`CRL_RW_LO] != `CRL_RW_LATCH;
			assign sel_latch = ctrl_wr && sc == 2'(g) && din_s[`CRL_RW_HI:`CRL_RW_LO] == `CRL_RW_LATCH;
			assign rb_hit    = is_rb && din_s[`CRL_RB_SEL_LO + g]; // [R6] [R16]
			assign wr_cnt    = wr_end && addr_s == 2'(g);
			assign rd_cnt    = rd_end && addr_s == 2'(g);
			assign fmt       = ctrl_r[5:4];

			always_comb
			begin
				ctrl_nxt = ctrl_r;
				cr_nxt   = cr_r;
				ol_nxt   = ol_r;
				ol_v_nxt = ol_v_r;
				st_nxt   = st_r;
				st_v_nxt = st_v_r;
				null_nxt = null_r;
				rmsb_nxt = rmsb_r;
				wmsb_nxt = wmsb_r;
				ld_nxt   = ld_r;
				// Load handshake first, so a same-cycle write still sets null
				if (loaded)
				begin
					null_nxt = 1'b0; // [R10]
					ld_nxt   = 1'b0;
				end
				if (rd_cnt)
				begin
					if (st_v_r)
						st_v_nxt = 1'b0; // [R14]
					else if (fmt == `CRL_RW_BOTH && !rmsb_r)
						rmsb_nxt = 1'b1; // [R5]
					else
					begin
						rmsb_nxt = 1'b0;
						ol_v_nxt = 1'b0; // [R3] [R7]
					end
				end
				if (wr_cnt)
				begin
					if (fmt == `CRL_RW_LSB)
					begin
						cr_nxt   = {8'h00, din_s};
						null_nxt = 1'b1; // [R10]
						ld_nxt   = 1'b1;
					end
					else if (fmt == `CRL_RW_MSB)
					begin
						cr_nxt   = {din_s, 8'h00};
						null_nxt = 1'b1; // [R10]
						ld_nxt   = 1'b1;
					end
					else if (!wmsb_r)
					begin
						cr_nxt[7:0] = din_s;
						wmsb_nxt    = 1'b1; // [R5]
						ld_nxt      = 1'b0;
					end
					else
					begin
						cr_nxt[15:8] = din_s;
						wmsb_nxt     = 1'b0;
						null_nxt     = 1'b1; // [R11]
						ld_nxt       = 1'b1;
					end
				end
				if (sel_latch && !ol_v_r)
				begin
					ol_nxt   = ce; // [R2] [R4]
					ol_v_nxt = 1'b1;
				end
				if (rb_hit && !din_s[`CRL_RB_COUNT_N] && !ol_v_r)
				begin
					ol_nxt   = ce; // [R8] [R13]
					ol_v_nxt = 1'b1;
				end
				if (rb_hit && !din_s[`CRL_RB_STATUS_N] && !st_v_r)
				begin
					st_nxt   = {out_lv, null_r, ctrl_r}; // [R9] [R12] [R13]
					st_v_nxt = 1'b1;
				end
				if (sel_ctrl)
				begin
					ctrl_nxt = din_s[5:0];
					null_nxt = 1'b1; // [R10]
					ol_v_nxt = 1'b0; // [R3]
					st_v_nxt = 1'b0;
					rmsb_nxt = 1'b0;
					wmsb_nxt = 1'b0;
					ld_nxt   = 1'b0;
				end
			end

			always_ff @(posedge clk or posedge reset)
			begin
				if (reset)
				begin
					ctrl_r <= `CRL_CTRL_RESET;
					cr_r   <= `CRL_COUNT_RESET;
					ol_r   <= `CRL_COUNT_RESET;
					ol_v_r <= 1'b0;
					st_r   <= 8'h00;
					st_v_r <= 1'b0;
					null_r <= 1'b1;
					rmsb_r <= 1'b0;
					wmsb_r <= 1'b0;
					ld_r   <= 1'b0;
				end
				else
				begin
					ctrl_r <= ctrl_nxt;
					cr_r   <= cr_nxt;
					ol_r   <= ol_nxt;
					ol_v_r <= ol_v_nxt;
					st_r   <= st_nxt;
					st_v_r <= st_v_nxt;
					null_r <= null_nxt;
					rmsb_r <= rmsb_nxt;
					wmsb_r <= wmsb_nxt;
					ld_r   <= ld_nxt;
				end
			end

			// Unlatched reads see the live element and may tear
			crl_pkg::crl_count_t src;
			assign src = ol_v_r ? ol_r : ce; // [R1]

			always_comb
			begin
				if (st_v_r)
					rd_byte[g] = st_r; // [R14]
				else if (fmt == `CRL_RW_MSB || (fmt == `CRL_RW_BOTH && rmsb_r))
					rd_byte[g] = src[15:8];
				else
					rd_byte[g] = src[7:0];
			end

			crl_channel u_channel
			(
				.clk                 (clk),
				.reset               (reset),
				.tick                (tick[g]),
				.gate_on             (gate_on[g]),
				.ctrl_wr             (sel_ctrl),
				// New mode must set the output level on the control write itself
				.op_sel              (ctrl_nxt[3:1]),
				.load_req            (ld_r),
				.count_load_register (cr_r),
				.count_value         (ce),
				.out_level           (out_lv),
				.loaded              (loaded)
			);

			assign counter_out[g] = out_lv;
		end
	endgenerate

	// ==========================================
	// Read data path
	crl_pkg::crl_byte_t dout_r, dout_nxt;

	always_comb
	begin
		if (addr_s == `CRL_ADDR_CTRL)
			dout_nxt = 8'h00;
		else
			dout_nxt = rd_byte[addr_s];
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			dout_r <= 8'h00;
		else
			dout_r <= dout_nxt;
	end

	assign data_out = dout_r;
	assign data_oe  = cs_s & rd_s & (addr_s != `CRL_ADDR_CTRL);
endmodule

// ### crl_top_properties.sv
// Port-level properties of the timer readout logic
module crl_top_checker
(
	input wire logic       clk,
	input wire logic       reset,
	input wire logic       cs_n,
	input wire logic       rd_n,
	input wire logic       wr_n,
	input wire logic [1:0] addr,
	input wire logic [7:0] data_in,
	input wire logic [7:0] data_out,
	input wire logic       data_oe,
	input wire logic [2:0] counter_clk,
	input wire logic [2:0] gate,
	input wire logic [2:0] counter_out
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	a_reset_quiet: assert property (disable iff (1'b0) reset |->
		data_out == 8'h00 && !data_oe && counter_out == 3'h0) else $error("reset outputs");
	a_oe_on_read: assert property ((!cs_n && !rd_n && addr != 2'h3)[*3] |-> data_oe)
		else $error("no drive on read");
	a_oe_off_ctrl: assert property ((addr == 2'h3)[*3] |-> !data_oe)
		else $error("drive on control address");
	a_oe_off_idle: assert property ((rd_n)[*3] |-> !data_oe)
		else $error("drive without read");
	a_oe_off_cs: assert property ((cs_n)[*3] |-> !data_oe)
		else $error("drive while deselected");
	a_oe_sync_lag: assert property ($fell(rd_n) |-> !data_oe)
		else $error("drive too early");
	// Counting and outputs only move on counter clock, gate or a write
	a_out_needs_clk: assert property ((counter_clk == $past(counter_clk) &&
		gate == $past(gate) && wr_n)[*6] |-> $stable(counter_out)) else $error("output moved");
	a_read_frozen: assert property ((!cs_n && !rd_n && $stable(addr) &&
		$stable(counter_clk))[*6] |-> $stable(data_out)) else $error("read byte moved");
endmodule
bind crl_top crl_top_checker u_chk(.clk(clk), .reset(reset), .cs_n(cs_n), .rd_n(rd_n),
	.wr_n(wr_n), .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
	.counter_clk(counter_clk), .gate(gate), .counter_out(counter_out));

// ### crl_host_model.sv
// Host processor model issuing read and write strobes
module crl_host_model
(
	input  wire logic       clk,
	output logic            cs_n,
	output logic            rd_n,
	output logic            wr_n,
	output logic [1:0]      addr,
	output logic [7:0]      data_in,
	input  wire logic [7:0] data_out
);
	timeunit 1ns;
	timeprecision 100ps;
	initial
	begin
		cs_n = 1'b1;
		rd_n = 1'b1;
		wr_n = 1'b1;
		addr = 2'h0;
		data_in = 8'h00;
	end
	task wr(input logic [1:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		data_in = d;
		cs_n = 1'b0;
		wr_n = 1'b0;
		repeat (5) @(negedge clk);
		wr_n = 1'b1;
		repeat (5) @(negedge clk);
		cs_n = 1'b1;
		// Stale bus data never looks valid
		data_in = ~d;
	endtask
	task rd(input logic [1:0] a, output logic [7:0] d);
		@(negedge clk);
		addr = a;
		cs_n = 1'b0;
		rd_n = 1'b0;
		repeat (5) @(negedge clk);
		d = data_out;
		rd_n = 1'b1;
		repeat (5) @(negedge clk);
		cs_n = 1'b1;
	endtask
endmodule

// ### crl_top_tb.sv
// Self-checking bench of the timer readout logic
module crl_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk = 1'b0;
	logic        reset = 1'b0;
	logic [2:0]  counter_clk = 3'h0;
	logic [2:0]  gate = 3'h0;
	logic        cs_n, rd_n, wr_n, data_oe;
	logic [1:0]  addr;
	logic [7:0]  data_in, data_out;
	logic [2:0]  counter_out;
	logic [15:0] n [3];
	int          k [3];
	int          errors = 0;
	int          checks = 0;
	int          seed = 32'hd21163af;
	always #12.5 clk = ~clk;
	crl_top u_crl_top(.clk(clk), .reset(reset), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
		.addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
		.counter_clk(counter_clk), .gate(gate), .counter_out(counter_out));
	crl_host_model u_host(.clk(clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
		.data_in(data_in), .data_out(data_out));
	function automatic logic [5:0] cw(logic sq);
		return sq ? 6'h36 : 6'h30;
	endfunction
	function automatic logic [7:0] stat(logic o, logic nl, logic [5:0] w);
		return {o, nl, w};
	endfunction
	// Square wave drops the odd bit and steps by two
	function automatic logic [15:0] cnt(logic [15:0] v, int j, logic sq);
		return sq ? (v & 16'hfffe) - 16'(2 * j) : v - 16'(j);
	endfunction
	task give_verdict;
		if (errors == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task chk(input logic [15:0] s, input logic [15:0] e, input string nm);
		checks++;
		if (s !== e)
		begin
			errors++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask
	task st(input int c, input logic [7:0] e);
		logic [7:0] b;
		u_host.wr(2'h3, 8'he0 | (8'h02 << c));
		u_host.rd(c[1:0], b);
		chk({8'h00, b}, {8'h00, e}, "status");
	endtask
	task rd16(input int c, output logic [15:0] v);
		u_host.rd(c[1:0], v[7:0]);
		u_host.rd(c[1:0], v[15:8]);
	endtask
	task pulse(input int c, input int m);
		repeat (m)
		begin
			@(negedge clk);
			counter_clk[c] = 1'b1;
			repeat (4) @(negedge clk);
			counter_clk[c] = 1'b0;
			repeat (4) @(negedge clk);
		end
	endtask
	initial
	begin
		logic [7:0]  b;
		logic [15:0] v;
		logic        sq;
		int          c;
		// Rising edge off the clock edge, so every flop sees the reset
		#1 reset = 1'b1;
		repeat (10) @(negedge clk);
		reset = 1'b0;
		repeat (4) @(negedge clk);
		u_host.rd(2'h3, b);
		chk({8'h00, b}, 16'h0000, "control read");
		for (c = 0; c < 3; c++)
		begin
			sq = (c == 2);
			n[c] = 16'h1000 | 16'($random(seed));
			u_host.wr(2'h3, {c[1:0], cw(sq)});
			st(c, stat(sq, 1'b1, cw(sq)));
			chk({15'h0000, counter_out[c]}, {15'h0000, sq}, "output pin");
			u_host.wr(c[1:0], n[c][7:0]);
			u_host.wr(c[1:0], n[c][15:8]);
			pulse(c, 1);
			st(c, stat(sq, 1'b0, cw(sq)));
			u_host.wr(2'h3, 8'hc0 | (8'h02 << c));
			gate[c] = 1'b1;
			pulse(c, 3);
			k[c] = 3;
			u_host.wr(2'h3, 8'hc0 | (8'h02 << c));
			u_host.rd(c[1:0], b);
			chk({8'h00, b}, {8'h00, stat(sq, 1'b0, cw(sq))}, "both status");
			rd16(c, v);
			chk(v, cnt(n[c], 0, sq), "both count");
		end
		u_host.wr(2'h3, 8'hde);
		rd16(0, v);
		chk(v, cnt(n[0], 3, 1'b0), "group count 0");
		pulse(1, 2);
		k[1] = 5;
		rd16(1, v);
		chk(v, cnt(n[1], 3, 1'b0), "group count 1");
		rd16(2, v);
		chk(v, cnt(n[2], 3, 1'b1), "group count 2");
		for (c = 0; c < 3; c++)
		begin
			sq = (c == 2);
			u_host.wr(2'h3, {c[1:0], 6'h00});
			pulse(c, 2);
			u_host.wr(2'h3, {c[1:0], 6'h00});
			u_host.rd(c[1:0], b);
			u_host.wr(c[1:0], 8'h5a);
			u_host.rd(c[1:0], v[15:8]);
			chk({v[15:8], b}, cnt(n[c], k[c], sq), "latched count");
			k[c] = k[c] + 2;
			st(c, stat(sq, 1'b0, cw(sq)));
			u_host.wr(c[1:0], 8'h01);
			st(c, stat(sq, 1'b1, cw(sq)));
		end
		gate = 3'h0;
		rd16(0, v);
		chk(v, cnt(n[0], k[0], 1'b0), "direct count");
		// Single-byte formats: low byte only, then high byte only
		u_host.wr(2'h3, 8'h50);
		u_host.wr(2'h1, 8'h37);
		pulse(1, 1);
		u_host.rd(2'h1, b);
		chk({8'h00, b}, 16'h0037, "low byte only");
		u_host.wr(2'h3, 8'h60);
		u_host.wr(2'h1, 8'h12);
		pulse(1, 1);
		u_host.wr(2'h3, 8'h40);
		u_host.rd(2'h1, b);
		chk({8'h00, b}, 16'h0012, "high byte only");
		give_verdict;
	end
	initial
	begin
		#200000;
		errors++;
		give_verdict;
	end
endmodule
